// ==== hdl/reset_seq_pkg.sv ====
/*
 power-on/power-down reset sequencer constants.
 assumes a single system clock at 100 MHz.
*/
package reset_seq_pkg;
    localparam int unsigned WAIT_OUTER = 512;
    localparam int unsigned WAIT_INNER = 256;
    localparam int unsigned WAIT_CYCLES = WAIT_OUTER * WAIT_INNER;
    localparam int unsigned WAIT_WIDTH = 18;
    localparam int unsigned PC_WIDTH = 11;
    localparam logic [10:0] PC_RESET = 11'h000;
    localparam logic PDR_ENABLE_RESET = 1'b0;
    typedef enum logic [1:0] {st_reset, st_wait, st_run} seq_state_t;
endpackage : reset_seq_pkg

// ==== hdl/stab_counter.sv ====
/*
 stabilisation wait counter: counts enabled cycles up to a terminal count.
 assumes clear is held whenever reset is asserted.
*/
`timescale 1ns/1ps
module stab_counter
#(
    parameter int unsigned COUNT = 131072,
    parameter int unsigned WIDTH = 18
)
(
    input wire logic clk,
    input wire logic clear,
    input wire logic count_en,
    output logic done
);
    logic [WIDTH:0] count;
    wire logic at_end = (count == (WIDTH + 1)'(COUNT));

    always_ff @(posedge clk)
    begin
        if (clear)
            count <= '0;
        else if (count_en && !at_end)
            count <= count + 1'b1;
    end

    assign done = at_end;
endmodule : stab_counter

// ==== hdl/reset_sequencer.sv ====
/*
 power-on/power-down reset sequencer: gates oscillator and system reset,
 runs the stabilisation wait and loads the program counter with zero.
 assumes detect inputs are synchronous levels from the voltage monitors.
*/
`timescale 1ns/1ps
module reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned WAIT_COUNT = WAIT_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic poweron_detect,
    input wire logic powerdown_detect,
    input wire logic enable_write,
    input wire logic enable_wdata,
    output logic powerdown_reset_enable_flag,
    output logic osc_enable,
    output logic sys_reset,
    output logic pc_load,
    output logic [PC_WIDTH-1:0] pc_value,
    output logic poweron_cause
);
    ////////////////////////////////////////////////////////////////////
    seq_state_t state;
    seq_state_t next_state;
    logic wait_done;
    logic next_cause;

    wire logic pdr_active = powerdown_detect && powerdown_reset_enable_flag;
    wire logic any_reset = rst || poweron_detect || pdr_active;
    wire logic in_reset = (state == st_reset);

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (rst || poweron_detect)
            powerdown_reset_enable_flag <= PDR_ENABLE_RESET;
        else if (enable_write)
            powerdown_reset_enable_flag <= enable_wdata;
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            st_reset: if (!any_reset) next_state = st_wait;
            st_wait: if (wait_done) next_state = st_run;
            st_run: next_state = st_run;
            default: next_state = st_reset;
        endcase
        if (any_reset)
            next_state = st_reset;
    end

    assign next_cause = poweron_detect ? 1'b1 : (pdr_active ? 1'b0 : poweron_cause);

    always_ff @(posedge clk)
    begin
        state <= next_state;
        poweron_cause <= (rst) ? 1'b1 : next_cause;
        pc_value <= PC_RESET;
        pc_load <= (state == st_wait) && (next_state == st_run);
    end

    ////////////////////////////////////////////////////////////////////
    assign osc_enable = !in_reset && !any_reset;
    assign sys_reset = (state != st_run);

    stab_counter #(.COUNT(WAIT_COUNT), .WIDTH(WAIT_WIDTH)) u_wait
    (
        .clk(clk),
        .clear(in_reset || any_reset),
        .count_en(osc_enable && state == st_wait),
        .done(wait_done)
    );

    ////////////////////////////////////////////////////////////////////
    // cycles since all sources went quiet, watched by the wait-length check
    logic [WAIT_WIDTH:0] quiet_count;

    always_ff @(posedge clk)
    begin
        if (any_reset)
            quiet_count <= '0;
        else if (state != st_run)
            quiet_count <= quiet_count + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    property p_osc_off;
        @(posedge clk) disable iff (rst) any_reset |-> !osc_enable;
    endproperty
    osc_stopped_a: assert property (p_osc_off) else $error("osc running in reset");
    por_reset_a: assert property (@(posedge clk) disable iff (rst)
        poweron_detect |=> sys_reset && state == st_reset) else $error("por ignored");
    por_clears_en_a: assert property (@(posedge clk) disable iff (rst)
        poweron_detect |=> !powerdown_reset_enable_flag) else $error("por kept enable");
    pdr_gate_a: assert property (@(posedge clk) disable iff (rst)
        powerdown_detect && !powerdown_reset_enable_flag && !poweron_detect
        && state == st_run |=> state == st_run) else $error("disabled pdr acted");
    pdr_hold_a: assert property (@(posedge clk) disable iff (rst)
        pdr_active[*2] |-> sys_reset) else $error("pdr released early");
    wait_run_a: assert property (@(posedge clk) disable iff (rst)
        state == st_wait && wait_done && !any_reset |=> state == st_run && pc_load)
        else $error("wait not ending");
    wait_start_a: assert property (@(posedge clk) disable iff (rst)
        $fell(in_reset) |-> !wait_done) else $error("counter not cleared");
    por_prio_a: assert property (@(posedge clk) disable iff (rst)
        poweron_detect && powerdown_detect |=> poweron_cause) else $error("pdr beat por");
    pc_zero_a: assert property (@(posedge clk) disable iff (rst)
        pc_load |-> pc_value == PC_RESET) else $error("pc not zero");
    recover_a: assert property (@(posedge clk) disable iff (rst)
        state == st_reset && !any_reset |=> state == st_wait) else $error("no wait");
    wait_length_a: assert property (@(posedge clk) disable iff (rst)
        pc_load |-> quiet_count == (WAIT_WIDTH + 1)'(WAIT_COUNT + 2))
        else $error("wait length wrong");
    pc_pulse_a: assert property (@(posedge clk) disable iff (rst)
        pc_load |=> !pc_load) else $error("pc load not one cycle");
    run_osc_a: assert property (@(posedge clk) disable iff (rst)
        state == st_run && !any_reset |-> osc_enable && !sys_reset)
        else $error("run without clock");
    flag_write_a: assert property (@(posedge clk) disable iff (rst)
        enable_write && !poweron_detect |=> powerdown_reset_enable_flag == $past(enable_wdata))
        else $error("enable write lost");
    cause_pdr_a: assert property (@(posedge clk) disable iff (rst)
        pdr_active && !poweron_detect |=> !poweron_cause) else $error("pdr cause lost");
    cov_run_c: cover property (@(posedge clk) pc_load);
    cov_pdr_c: cover property (@(posedge clk) pdr_active ##1 !any_reset);
    cov_por_c: cover property (@(posedge clk) poweron_detect ##1 !poweron_detect);
    cov_rst_c: cover property (@(posedge clk) rst ##1 !rst);
    cov_restart_c: cover property (@(posedge clk) state == st_wait ##1 state == st_reset);
endmodule : reset_sequencer

// ==== tb/supply_monitor.sv ====
/*
 supply monitor model: presents the supply-rise and supply-drop levels.
 assumes the bench steers both levels at the falling clock edge.
*/
`timescale 1ns/1ps
module supply_monitor
(
    input wire logic por_req,
    input wire logic pdr_req,
    output logic poweron_detect,
    output logic powerdown_detect
);
    assign poweron_detect = por_req;
    assign powerdown_detect = pdr_req;
endmodule : supply_monitor

// ==== tb/tb_reset_sequencer.sv ====
/*
 bench for the reset sequencer, one task per scenario.
 assumes WAIT_COUNT shortened to 8 and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module tb_reset_sequencer
    import reset_seq_pkg::*;
;
    localparam int W = 8;
    logic clk = 0, rst = 1, por = 1, pdr = 0, we = 0, wd = 0;
    wire po, pd, flag, osc, sr, pl, cause;
    wire [PC_WIDTH-1:0] pcv;
    int num_errors = 0, cmp_count = 0;
    always #5 clk = ~clk;
    supply_monitor mon(.por_req(por), .pdr_req(pdr), .poweron_detect(po),
        .powerdown_detect(pd));
    reset_sequencer #(.WAIT_COUNT(W)) uut(.clk(clk), .rst(rst), .poweron_detect(po),
        .powerdown_detect(pd), .enable_write(we), .enable_wdata(wd),
        .powerdown_reset_enable_flag(flag), .osc_enable(osc), .sys_reset(sr),
        .pc_load(pl), .pc_value(pcv), .poweron_cause(cause));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e)
        begin
            $display("BAD %s exp %h seen %h", n, e, s);
            num_errors++;
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task nc(input int k);
        repeat (k) @(negedge clk);
    endtask : nc
    task wr_flag(input logic v);
        we = 1;
        wd = v;
        nc(1);
        we = 0;
    endtask : wr_flag
    task run_wait(input logic c);
        int n;
        n = 0;
        while (pl !== 1'b1 && n < 50)
        begin
            nc(1);
            n++;
        end
        if (n == 50)
        begin
            num_errors++;
            end_of_test;
        end
        chk("wait", n, W + 2);
        chk("pc", pcv, PC_RESET);
        chk("sr", sr, 0);
        chk("cause", cause, c);
        nc(1);
        chk("pl", pl, 0);
    endtask : run_wait
    ////////////////////////////////////////////////////////////////////////
    task t_por;
        nc(6);
        rst = 0;
        wr_flag(1);
        chk("osc", osc, 0);
        chk("sr", sr, 1);
        chk("flag", flag, 0);
        por = 0;
        run_wait(1);
        $display("t_por done");
    endtask : t_por
    task t_pdr_off;
        pdr = 1;
        nc(3);
        chk("sr", sr, 0);
        chk("osc", osc, 1);
        pdr = 0;
        $display("t_pdr_off done");
    endtask : t_pdr_off
    task t_pdr;
        wr_flag(1);
        chk("flag", flag, 1);
        pdr = 1;
        nc(1);
        chk("sr", sr, 1);
        chk("osc", osc, 0);
        nc(20);
        chk("sr", sr, 1);
        pdr = 0;
        nc(4);
        pdr = 1;
        nc(1);
        pdr = 0;
        run_wait(0);
        $display("t_pdr done");
    endtask : t_pdr
    task t_rst;
        wr_flag(1);
        rst = 1;
        nc(2);
        chk("osc", osc, 0);
        chk("sr", sr, 1);
        chk("flag", flag, 0);
        rst = 0;
        run_wait(1);
        $display("t_rst done");
    endtask : t_rst
    task t_prio;
        wr_flag(1);
        chk("flag", flag, 1);
        pdr = 1;
        por = 1;
        nc(1);
        chk("osc", osc, 0);
        pdr = 0;
        por = 0;
        chk("flag", flag, 0);
        run_wait(1);
        $display("t_prio done");
    endtask : t_prio
    initial
    begin
        t_por;
        t_pdr_off;
        t_pdr;
        t_rst;
        t_prio;
        end_of_test;
    end
endmodule : tb_reset_sequencer
